/* src/xoi_top.sv */
// address routing and strobe timing for the external data memory interface
//
// Function
// [R1] - mode 10 splits space, bank select active
// [R2] - split: below boundary on-chip, else external
// [R3] - split 8-bit: bank high nibble, pointer low
// [R4] - split 16-bit: pointer routes, drive 12 bits
// [R5] - mode 11: everything off-chip, xram hidden
// [R6] - ext-only 8-bit: ignore bank, upper undriven
// [R7] - ext-only 16-bit: pointer gives all 12 bits
// [R8] - setup, hold, strobes, ale programmable in clocks
// [R9] - off-chip access: parameters plus five clocks
// [R10] - multiplexed: ale adds two clocks minimum
// [R11] - setup and hold reset to maximum
// [R12] - no strobes or ale for on-chip access
`timescale 1ns/1ps
`include "xoi_defs.svh"

module xoi_top #(
    parameter logic [11:0] XRAM_BOUNDARY = 12'h200
) (
    input wire logic clk,
    input wire logic srst,
    input wire xoi_pkg::xoi_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output xoi_pkg::xoi_rsp_t rsp,
    output xoi_pkg::xoi_xram_t xram,
    output xoi_pkg::xoi_pins_t pins,
    input wire logic [7:0] ad_in,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import xoi_pkg::*;

    xoi_state_t st;
    xoi_state_t next_st;

    logic [1:0] mode;
    logic mux_mode;
    logic [1:0] ale_w;
    logic [1:0] setup_w;
    logic [3:0] strobe_w;
    logic [1:0] hold_w;

    assign mode = st.cfg[`XOI_CFG_MODE_HI:`XOI_CFG_MODE_LO];
    assign mux_mode = st.cfg[`XOI_CFG_MUX_BIT];
    assign ale_w = st.cfg[`XOI_CFG_ALE_HI:`XOI_CFG_ALE_LO];
    assign setup_w = st.timing[`XOI_TM_SETUP_HI:`XOI_TM_SETUP_LO];
    assign strobe_w = st.timing[`XOI_TM_WIDTH_HI:`XOI_TM_WIDTH_LO];
    assign hold_w = st.timing[`XOI_TM_HOLD_HI:`XOI_TM_HOLD_LO];

    // effective 12-bit address of a request
    function automatic logic [11:0] eff_addr(input xoi_req_t r,
                                             input logic [1:0] m,
                                             input logic [3:0] bk);
        if (r.wide) begin
            eff_addr = r.data_pointer_reg[11:0]; // [R4] [R7]
        end else if (m == `XOI_MODE_SPLIT_BANK) begin
            eff_addr = {bk, r.ptr8}; // [R3]
        end else begin
            eff_addr = {4'h0, r.ptr8}; // [R6]
        end
    endfunction : eff_addr

    // true when the request goes to the external bus
    function automatic logic goes_ext(input xoi_req_t r,
                                      input logic [1:0] m,
                                      input logic [3:0] bk);
        logic [15:0] full;
        full = r.wide ? r.data_pointer_reg : {4'h0, bk, r.ptr8};
        if (m == `XOI_MODE_EXT_ONLY) begin
            goes_ext = 1'b1; // [R5]
        end else if (m == `XOI_MODE_SPLIT_BANK) begin
            goes_ext = (full >= {4'h0, XRAM_BOUNDARY}); // [R1] [R2]
        end else begin
            goes_ext = 1'b0;
        end
    endfunction : goes_ext

    // register read mux; unmapped offsets answer slave error
    function automatic logic [32:0] reg_read(input xoi_state_t s,
                                             input logic [3:0] a);
        case (a)
            `XOI_OFS_CONFIG: reg_read = {1'b0, 24'h0, s.cfg};
            `XOI_OFS_BANK: reg_read = {1'b0, 28'h0, s.bank};
            `XOI_OFS_TIMING: reg_read = {1'b0, 24'h0, s.timing};
            `XOI_OFS_STATUS: reg_read = {1'b0, 30'h0, s.rsp.ext,
                                         s.phase != PH_IDLE};
            default: reg_read = {1'b1, 32'h0};
        endcase
    endfunction : reg_read

    always_comb begin
        logic [32:0] rd;
        logic [11:0] a;
        logic e;
        logic fin;
        rd = 33'h0;
        a = 12'h0;
        e = 1'b0;
        fin = 1'b0;
        next_st = st;
        next_st.rsp.done = 1'b0;
        next_st.xram.sel = 1'b0;

        // register bus: write address and data taken in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.awv = 1'b1;
            next_st.awaddr = s_axi_awaddr;
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.wv = 1'b1;
            next_st.wdata = s_axi_wdata[7:0];
            next_st.wstrb0 = s_axi_wstrb[0];
            next_st.wready = 1'b0;
        end
        if (st.awv && st.wv && !st.bvalid) begin
            next_st.awv = 1'b0;
            next_st.wv = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `XOI_RESP_OKAY;
            case (st.awaddr)
                `XOI_OFS_CONFIG: begin
                    if (st.wstrb0) begin
                        next_st.cfg = {3'h0, st.wdata[4:0]};
                    end
                end
                `XOI_OFS_BANK: begin
                    if (st.wstrb0) begin
                        next_st.bank = st.wdata[3:0];
                    end
                end
                `XOI_OFS_TIMING: begin
                    if (st.wstrb0) begin
                        next_st.timing = st.wdata; // [R8]
                    end
                end
                `XOI_OFS_STATUS: ;
                default: next_st.bresp = `XOI_RESP_SLVERR;
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
        if (s_axi_arvalid && st.arready) begin
            rd = reg_read(st, s_axi_araddr);
            next_st.rdata = rd[31:0];
            next_st.rresp = rd[32] ? `XOI_RESP_SLVERR : `XOI_RESP_OKAY;
            next_st.rvalid = 1'b1;
            next_st.arready = 1'b0;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end

        // access sequencer; settings are read live, so change them idle
        unique case (st.phase)
            PH_IDLE: begin
                if (req_valid && st.req_ready) begin
                    a = eff_addr(req, mode, st.bank);
                    e = goes_ext(req, mode, st.bank);
                    next_st.rsp.ext = e;
                    if (e) begin
                        next_st.cur = req;
                        next_st.cur_addr = a;
                        // ext-only 8-bit leaves upper address to ports
                        next_st.cur_hi_drv = req.wide ||
                            (mode != `XOI_MODE_EXT_ONLY); // [R6]
                        next_st.req_ready = 1'b0;
                        next_st.phase = PH_START;
                    end else begin
                        // on-chip: one-cycle handoff, pins untouched
                        next_st.xram = '{1'b1, req.wr, a, req.wdata}; // [R12]
                        next_st.rsp.done = 1'b1;
                    end
                end
            end
            PH_START: begin
                if (mux_mode) begin
                    next_st.phase = PH_ALE;
                    next_st.cnt = {2'h0, ale_w}; // [R10]
                end else if (setup_w != 2'h0) begin
                    next_st.phase = PH_SETUP;
                    next_st.cnt = {2'h0, setup_w - 2'h1};
                end else begin
                    next_st.phase = PH_STRB;
                    next_st.cnt = strobe_w;
                end
            end
            PH_ALE: begin
                if (st.cnt == 4'h0) begin
                    next_st.phase = PH_ALEH; // [R10]
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            PH_ALEH: begin
                if (setup_w != 2'h0) begin
                    next_st.phase = PH_SETUP;
                    next_st.cnt = {2'h0, setup_w - 2'h1};
                end else begin
                    next_st.phase = PH_STRB;
                    next_st.cnt = strobe_w;
                end
            end
            PH_SETUP: begin
                if (st.cnt == 4'h0) begin
                    next_st.phase = PH_STRB; // [R8]
                    next_st.cnt = strobe_w;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            PH_STRB: begin
                if (st.cnt == 4'h0) begin
                    if (!st.cur.wr) begin
                        next_st.rsp.rdata = ad_in;
                    end
                    if (hold_w != 2'h0) begin
                        next_st.phase = PH_HOLD;
                        next_st.cnt = {2'h0, hold_w - 2'h1};
                    end else begin
                        next_st.phase = PH_FIN;
                        next_st.cnt = `XOI_FIN_CYCLES - 4'h1;
                    end
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            PH_HOLD: begin
                if (st.cnt == 4'h0) begin
                    next_st.phase = PH_FIN; // [R8]
                    next_st.cnt = `XOI_FIN_CYCLES - 4'h1;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            PH_FIN: begin
                if (st.cnt == 4'h0) begin
                    fin = 1'b1; // [R9]
                    next_st.phase = PH_IDLE;
                    next_st.rsp.done = 1'b1;
                    next_st.req_ready = 1'b1;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
        endcase

        // pins follow the phase being entered so they leave a flop
        next_st.pins.ale = (next_st.phase == PH_ALE); // [R10]
        next_st.pins.rd_n = !(next_st.phase == PH_STRB
                              && !next_st.cur.wr); // [R12]
        next_st.pins.wr_n = !(next_st.phase == PH_STRB
                              && next_st.cur.wr); // [R12]
        if (next_st.phase == PH_IDLE || fin) begin
            next_st.pins.addr_hi_oe = 1'b0;
            next_st.pins.addr_lo_oe = 1'b0;
            next_st.pins.ad_oe = 1'b0;
        end else begin
            next_st.pins.addr = next_st.cur_addr; // [R3] [R4] [R7]
            next_st.pins.addr_hi_oe = next_st.cur_hi_drv; // [R3] [R6]
            next_st.pins.addr_lo_oe = !mux_mode;
            if (mux_mode && (next_st.phase == PH_START
                             || next_st.phase == PH_ALE)) begin
                next_st.pins.ad_out = next_st.cur_addr[7:0];
                next_st.pins.ad_oe = 1'b1;
            end else begin
                next_st.pins.ad_out = next_st.cur.wdata;
                next_st.pins.ad_oe = next_st.cur.wr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.phase <= PH_IDLE;
            st.req_ready <= 1'b1;
            st.pins.rd_n <= 1'b1;
            st.pins.wr_n <= 1'b1;
            st.cfg <= `XOI_CFG_RESET;
            st.bank <= `XOI_BANK_RESET;
            st.timing <= `XOI_TIMING_RESET; // [R11]
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign req_ready = st.req_ready;
    assign rsp = st.rsp;
    assign xram = st.xram;
    assign pins = st.pins;
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;
endmodule : xoi_top

/* src/xoi_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef XOI_DEFS_SVH
`define XOI_DEFS_SVH
`define XOI_OFS_CONFIG 4'h0
`define XOI_OFS_BANK 4'h4
`define XOI_OFS_TIMING 4'h8
`define XOI_OFS_STATUS 4'hC
`define XOI_CFG_MUX_BIT 4
`define XOI_CFG_MODE_HI 3
`define XOI_CFG_MODE_LO 2
`define XOI_CFG_ALE_HI 1
`define XOI_CFG_ALE_LO 0
`define XOI_TM_SETUP_HI 7
`define XOI_TM_SETUP_LO 6
`define XOI_TM_WIDTH_HI 5
`define XOI_TM_WIDTH_LO 2
`define XOI_TM_HOLD_HI 1
`define XOI_TM_HOLD_LO 0
`define XOI_CFG_RESET 8'h00
`define XOI_BANK_RESET 4'h0
`define XOI_TIMING_RESET 8'hFF
`define XOI_MODE_SPLIT_BANK 2'h2
`define XOI_MODE_EXT_ONLY 2'h3
`define XOI_FIN_CYCLES 4'h3
`define XOI_RESP_OKAY 2'h0
`define XOI_RESP_SLVERR 2'h2
`endif

/* src/xoi_pkg.sv */
// types shared by the external data memory interface
package xoi_pkg;
    typedef enum logic [2:0] {
        PH_IDLE, PH_START, PH_ALE, PH_ALEH, PH_SETUP, PH_STRB, PH_HOLD,
        PH_FIN
    } xoi_phase_t;

    // one external-data move instruction from the cpu
    typedef struct packed {
        logic wr;
        logic wide;
        logic [7:0] ptr8;
        logic [15:0] data_pointer_reg;
        logic [7:0] wdata;
    } xoi_req_t;

    typedef struct packed {
        logic done;
        logic ext;
        logic [7:0] rdata;
    } xoi_rsp_t;

    // access handed to on-chip xram
    typedef struct packed {
        logic sel;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } xoi_xram_t;

    typedef struct packed {
        logic [11:0] addr;
        logic addr_hi_oe;
        logic addr_lo_oe;
        logic [7:0] ad_out;
        logic ad_oe;
        logic rd_n;
        logic wr_n;
        logic ale;
    } xoi_pins_t;

    typedef struct packed {
        xoi_phase_t phase;
        logic [3:0] cnt;
        xoi_req_t cur;
        logic [11:0] cur_addr;
        logic cur_hi_drv;
        logic req_ready;
        xoi_rsp_t rsp;
        xoi_xram_t xram;
        xoi_pins_t pins;
        logic [7:0] cfg;
        logic [3:0] bank;
        logic [7:0] timing;
        logic awv;
        logic [3:0] awaddr;
        logic wv;
        logic [7:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } xoi_state_t;
endpackage : xoi_pkg

/* verification/xoi_chk_assertions.sv */
// port checker for the external data memory interface
`timescale 1ns/1ps
module xoi_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_ready,
    input wire xoi_pkg::xoi_rsp_t rsp,
    input wire xoi_pkg::xoi_pins_t pins,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    import xoi_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_quiet;
        pins.rd_n && pins.wr_n && !pins.ale;
    endsequence
    sequence s_ale_gap;
        pins.ale ##[1:4] !pins.ale;
    endsequence
    a_onchip_quiet:
        assert property (rsp.done && !rsp.ext |-> s_quiet)
        else $error("bus strobe on an on-chip access");
    a_ext_min_len:
        assert property ($fell(req_ready) |-> !rsp.done [*5])
        else $error("off-chip access too short");
    a_ext_max_len:
        assert property ($fell(req_ready) |-> ##[4:40] rsp.done)
        else $error("off-chip access never finished");
    a_ale_then_gap:
        assert property ($rose(pins.ale) |-> s_ale_gap ##0 s_quiet)
        else $error("latch pulse not followed by a quiet cycle");
    a_mux_min_len:
        assert property ($rose(pins.ale) |-> !rsp.done [*5])
        else $error("multiplexed access too short");
    a_strobe_busy:
        assert property (!pins.rd_n || !pins.wr_n |->
            !req_ready && (pins.rd_n || pins.wr_n))
        else $error("strobe while idle or both strobes low");
    a_addr_steady:
        assert property (!pins.rd_n && $past(!pins.rd_n) |->
            $stable(pins.addr) && $stable(pins.addr_hi_oe))
        else $error("address moved under the read strobe");
    a_done_frees:
        assert property (rsp.done |-> req_ready)
        else $error("done without ready");
    a_resp_held:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
endmodule : xoi_chk

bind xoi_top xoi_chk u_chk (.clk(clk), .srst(srst),
    .req_ready(req_ready), .rsp(rsp), .pins(pins),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

/* verification/xoi_ext_mem.sv */
// behavioural external parallel memory on the interface pins
`timescale 1ns/1ps
module xoi_ext_mem (
    input wire logic clk,
    input wire xoi_pkg::xoi_pins_t pins,
    output logic [7:0] ad_in
);
    import xoi_pkg::*;
    logic [7:0] mem [4096];
    logic [7:0] lat = 8'h00;
    logic [7:0] idle_q = 8'h00;
    logic [11:0] a;
    // undriven upper nibble reads as zero, like pulled-down port pins
    assign a = {pins.addr_hi_oe ? pins.addr[11:8] : 4'h0,
                pins.addr_lo_oe ? pins.addr[7:0] : lat};
    // released bus toggles so a stale byte can never look valid
    assign ad_in = pins.rd_n ? idle_q : mem[a];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end
    always @(posedge clk) begin
        idle_q <= ~idle_q;
        if (pins.ale) begin
            lat <= pins.ad_out;
        end
        if (!pins.wr_n) begin
            mem[a] <= pins.ad_out;
        end
    end
endmodule : xoi_ext_mem

/* verification/testbench.sv */
// self-checking bench for the external data memory interface
`timescale 1ns/1ps
`include "xoi_defs.svh"
module testbench;
    import xoi_pkg::*;
    localparam logic [11:0] BND = 12'h200;
    logic clk = 1'b0, srst = 1'b1, req_valid = 1'b0, req_ready;
    xoi_req_t req = '0;
    xoi_rsp_t rsp;
    xoi_xram_t xram;
    xoi_pins_t pins;
    logic [7:0] ad_in;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    int failures = 0, checks_done = 0;
    int mode = 0, mux = 0, ale = 0, bank = 0, stp = 3, wid = 15, hld = 3;
    logic [7:0] em [4096];
    logic [7:0] cfgs [5] = '{8'h0C, 8'h08, 8'h19, 8'h1E, 8'h04};

    xoi_top #(.XRAM_BOUNDARY(BND)) dut (.clk(clk), .srst(srst), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .rsp(rsp),
        .xram(xram), .pins(pins), .ad_in(ad_in),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    xoi_ext_mem u_mem (.clk(clk), .pins(pins), .ad_in(ad_in));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wr_reg(logic [3:0] a, logic [31:0] d, logic [1:0] er);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            // late bready makes the slave hold its response a cycle
            if (n == 3) bready <= 1'b1;
        end while (!(bvalid && bready) && n < 50);
        bready <= 1'b0;
        chk("bresp", {1'b1, er}, {bvalid, bresp});
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(logic [3:0] a, logic [31:0] e, logic [1:0] er);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        chk("rresp", {1'b1, er}, {rvalid, rresp});
        chk("rdata_reg", e, rdata);
        @(posedge clk);
    endtask : rd_reg

    task automatic set_cfg(logic [7:0] c);
        mode = c[3:2];
        mux = c[4];
        ale = c[1:0];
        wr_reg(`XOI_OFS_CONFIG, 32'(c), 2'h0);
        rd_reg(`XOI_OFS_CONFIG, 32'(c), 2'h0);
    endtask : set_cfg

    task automatic set_tm(int s, int w, int h);
        stp = s;
        wid = w;
        hld = h;
        wr_reg(`XOI_OFS_TIMING, 32'(s * 64 + w * 4 + h), 2'h0);
        rd_reg(`XOI_OFS_TIMING, 32'(s * 64 + w * 4 + h), 2'h0);
    endtask : set_tm

    task automatic acc(logic w, logic wd, logic [7:0] p, logic [15:0] dp);
        int n, en, off;
        logic [15:0] ea;
        logic [11:0] a, sa;
        logic [7:0] wb;
        logic hs, hx, lo, oe;
        wb = 8'($urandom);
        ea = wd ? dp : {4'h0, 4'(bank), p};
        off = (mode == 3) || (mode == 2 && ea >= BND);
        a = wd ? dp[11:0] : {mode == 2 ? 4'(bank) : 4'h0, p};
        en = off ? stp + wid + hld + 5 + (mux ? ale + 2 : 0) : 0;
        hx = (mode == 2) || wd;
        req <= '{wr: w, wide: wd, ptr8: p, data_pointer_reg: dp, wdata: wb};
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        hs = 1'b0;
        lo = 1'b0;
        oe = 1'b0;
        sa = 12'h000;
        // an on-chip done pulse stands right after the take edge
        #1;
        while (!rsp.done && n < 80) begin
            @(posedge clk);
            #1;
            n++;
            if (!pins.rd_n || !pins.wr_n) begin
                hs = pins.addr_hi_oe;
                lo = pins.addr_lo_oe;
                oe = pins.ad_oe;
                sa = pins.addr;
            end
        end
        chk("cycles", en, n);
        chk("ext", off, rsp.ext);
        if (!off) begin
            chk("xram_sel", 1'b1, xram.sel);
            chk("xram_addr", {w, a}, {xram.wr, xram.addr});
            chk("xram_wdata", wb, xram.wdata);
        end else begin
            chk("addr_hi_oe", hx, hs);
            chk("addr_lo_oe", !mux, lo);
            chk("ad_oe", w, oe);
            if (hx) chk("addr_hi", a[11:8], sa[11:8]);
            if (!mux) chk("addr_lo", a[7:0], sa[7:0]);
            if (w) em[a] = wb;
            if (w) chk("ext_wr", wb, u_mem.mem[a]);
            else chk("ext_rd", em[a], rsp.rdata);
        end
        @(posedge clk);
    endtask : acc

    task automatic rnd_acc();
        logic [15:0] dp;
        case ($urandom_range(0, 3))
            0: dp = {4'h0, BND - 12'h1};
            1: dp = {4'h0, BND};
            default: dp = 16'($urandom);
        endcase
        acc(1'($urandom), 1'($urandom), 8'($urandom), dp);
    endtask : rnd_acc

    initial begin
        void'($urandom(94));
        for (int i = 0; i < 4096; i++) em[i] = 8'(i) ^ 8'hA5;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_reg(`XOI_OFS_CONFIG, 32'h0, 2'h0);
        rd_reg(`XOI_OFS_TIMING, 32'hFF, 2'h0);
        rd_reg(4'h2, 32'h0, `XOI_RESP_SLVERR);
        wr_reg(4'h2, 32'h1, `XOI_RESP_SLVERR);
        acc(1'b0, 1'b1, 8'h00, 16'h0FFF);
        $display("test reset finished");
        set_cfg(8'h08);
        acc(1'b1, 1'b1, 8'h00, {4'h0, BND});
        acc(1'b0, 1'b1, 8'h00, {4'h0, BND});
        rd_reg(`XOI_OFS_STATUS, 32'h2, 2'h0);
        $display("test max_timing finished");
        foreach (cfgs[k]) begin
            set_cfg(cfgs[k]);
            set_tm(0, 0, 0);
            repeat (6) rnd_acc();
            set_tm($urandom_range(0, 3), $urandom_range(0, 15),
                $urandom_range(0, 3));
            bank = $urandom_range(0, 15);
            wr_reg(`XOI_OFS_BANK, 32'(bank), 2'h0);
            repeat (8) rnd_acc();
            $display("test config %h finished", cfgs[k]);
        end
        wrap_up();
    end

    initial begin
        #1000000;
        failures++;
        wrap_up();
    end
endmodule : testbench
